/* File: slf_pkg.sv */
// Purpose: Constants for the serial line format block
// Assumes: 10 MHz system clock
// Notes:   Field positions and codes of the line format and flow settings
package slf_pkg;
    localparam int          CLK_HZ          = 10000000;
    localparam int          DEF_BAUD        = 9600;
    localparam logic [7:0]  LINE_FMT_RST    = 8'h4C;
    localparam logic [7:0]  FLOW_RST        = 8'h00;
    localparam logic [3:0]  BAUD_SEL_RST    = 4'h5;
    localparam int          IF_LSB          = 0;
    localparam int          WL_LSB          = 2;
    localparam int          PAR_LSB         = 4;
    localparam int          STOP_LSB        = 6;
    localparam logic [1:0]  IF_RS232        = 2'h0;
    localparam logic [1:0]  IF_RS422        = 2'h1;
    localparam logic [1:0]  IF_RS485_2W     = 2'h3;
    localparam logic [1:0]  WL_SEVEN        = 2'h2;
    localparam logic [1:0]  PAR_EVEN        = 2'h3;
    localparam logic [1:0]  PAR_ODD         = 2'h1;
    localparam logic [1:0]  STOP_TWO        = 2'h3;
    localparam logic [7:0]  FLOW_NONE       = 8'h00;
    localparam logic [7:0]  FLOW_XON        = 8'h01;
    localparam logic [7:0]  FLOW_RTSCTS     = 8'h02;
    localparam logic [7:0]  FLOW_XON_PASS   = 8'h05;
    localparam logic [7:0]  CHAR_XON        = 8'h11;
    localparam logic [7:0]  CHAR_XOFF       = 8'h13;
    localparam int          NUM_RATES       = 13;
    localparam int          HI_RATE_FIRST   = 11;
    localparam logic [3:0]  RATE_IDX_MAX    = 4'hC;
endpackage : slf_pkg

/* File: slf_serial_channel.sv */
// Purpose: Serial channel with configurable line format, rate and flow control
// Assumes: One clock, registers loaded through a plain write port
// Notes:   Framing restarts on any rate change
`timescale 1ns/1ns
module slf_serial_channel
    import slf_pkg::*;
#(
    parameter bit HI_RATES = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cfg_we,
    input  wire logic [1:0]  cfg_addr,
    input  wire logic [7:0]  cfg_wdata,
    output logic      [7:0]  cfg_rdata,
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_data,
    output logic             tx_ready,
    output logic             rx_valid,
    output logic      [7:0]  rx_data,
    output logic             rx_parity_err,
    input  wire logic        rx_hold,
    output logic             serial_tx,
    input  wire logic        serial_rx,
    input  wire logic        cts_n,
    output logic             rts_n,
    output logic             configurable_pin
);
    ////////////////////////////////////////////////////////////////////////
    // Registers: address 0 line format, 1 flow, 2 rate index
    logic [7:0] line_format_setting_ff, nxt_line_format_setting;
    logic [7:0] flow_control_setting_ff, nxt_flow_control_setting;
    logic [3:0] rate_sel_ff, nxt_rate_sel;
    logic       restart;

    always_comb begin
        nxt_line_format_setting  = line_format_setting_ff;
        nxt_flow_control_setting = flow_control_setting_ff;
        nxt_rate_sel             = rate_sel_ff;
        restart                  = 1'b0;
        if (cfg_we) begin
            case (cfg_addr)
                2'h0: nxt_line_format_setting = cfg_wdata;
                2'h1: nxt_flow_control_setting = cfg_wdata;
                2'h2: begin
                    // Out of range or unsupported fast rates are refused
                    if (cfg_wdata[3:0] <= RATE_IDX_MAX &&
                        (HI_RATES || cfg_wdata[3:0] < 4'(HI_RATE_FIRST))) begin
                        nxt_rate_sel = cfg_wdata[3:0];
                        restart      = cfg_wdata[3:0] != rate_sel_ff;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_format_setting_ff  <= LINE_FMT_RST;
            flow_control_setting_ff <= FLOW_RST;
            rate_sel_ff             <= BAUD_SEL_RST;
        end else begin
            line_format_setting_ff  <= nxt_line_format_setting;
            flow_control_setting_ff <= nxt_flow_control_setting;
            rate_sel_ff             <= nxt_rate_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded format; only each option's own bits are looked at
    logic [1:0] if_mode;
    logic       seven_bit, par_en, par_odd, two_stop, half_duplex, tx_busy;
    assign if_mode     = line_format_setting_ff[IF_LSB +: 2];
    assign seven_bit   = line_format_setting_ff[WL_LSB +: 2] == WL_SEVEN;
    assign par_en      = line_format_setting_ff[PAR_LSB];
    assign par_odd     = line_format_setting_ff[PAR_LSB +: 2] == PAR_ODD;
    assign two_stop    = line_format_setting_ff[STOP_LSB +: 2] == STOP_TWO;
    assign half_duplex = if_mode == IF_RS485_2W;

    always_comb begin
        case (cfg_addr)
            2'h0:    cfg_rdata = line_format_setting_ff;
            2'h1:    cfg_rdata = flow_control_setting_ff;
            2'h2:    cfg_rdata = {4'h0, rate_sel_ff};
            default: cfg_rdata = {6'h00, if_mode};
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Divider per rate; standard steps from 300 upward
    function automatic logic [15:0] half_div(input logic [3:0] sel);
        int rate;
        case (sel)
            4'h0:    rate = 300;
            4'h1:    rate = 600;
            4'h2:    rate = 1200;
            4'h3:    rate = 2400;
            4'h4:    rate = 4800;
            4'h5:    rate = DEF_BAUD;
            4'h6:    rate = 19200;
            4'h7:    rate = 38400;
            4'h8:    rate = 57600;
            4'h9:    rate = 115200;
            4'hA:    rate = 230400;
            4'hB:    rate = 460800;
            4'hC:    rate = 921600;
            default: rate = DEF_BAUD;
        endcase
        // Fast rates are coarse at 10 MHz; minimum one cycle
        half_div = 16'((CLK_HZ / rate > 1) ? CLK_HZ / rate : 1);
    endfunction

    logic [15:0] bit_div;
    assign bit_div = half_div(rate_sel_ff);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: three stages, change accepted when last two agree
    logic [2:0] rx_sync_ff, nxt_rx_sync, cts_sync_ff, nxt_cts_sync;
    logic       rx_in_ff, nxt_rx_in, cts_in_ff, nxt_cts_in;
    always_comb begin
        nxt_rx_sync  = {rx_sync_ff[1:0], serial_rx};
        nxt_cts_sync = {cts_sync_ff[1:0], cts_n};
        nxt_rx_in    = (rx_sync_ff[2] == rx_sync_ff[1]) ? rx_sync_ff[2] : rx_in_ff;
        nxt_cts_in   = (cts_sync_ff[2] == cts_sync_ff[1]) ? cts_sync_ff[2] : cts_in_ff;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_sync_ff  <= 3'h7;
            cts_sync_ff <= 3'h7;
            rx_in_ff    <= 1'b1;
            cts_in_ff   <= 1'b1;
        end else begin
            rx_sync_ff  <= nxt_rx_sync;
            cts_sync_ff <= nxt_cts_sync;
            rx_in_ff    <= nxt_rx_in;
            cts_in_ff   <= nxt_cts_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver, samples mid-bit
    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_TAIL  = 4'h8
    } slf_rx_state_type;
    slf_rx_state_type rx_st_ff, nxt_rx_st;
    logic [15:0] rx_cnt_ff, nxt_rx_cnt;
    logic [3:0]  rx_bit_ff, nxt_rx_bit;
    logic [8:0]  rx_sh_ff, nxt_rx_sh, rx_al;
    logic [7:0]  rx_data_ff, nxt_rx_data;
    logic        rx_valid_ff, nxt_rx_valid, rx_perr_ff, nxt_rx_perr;
    logic        xoff_seen_ff, nxt_xoff_seen;
    logic [3:0]  rx_len;
    logic [7:0]  rx_word;
    logic        rx_xon_flow;

    assign rx_xon_flow = flow_control_setting_ff == FLOW_XON ||
                         flow_control_setting_ff == FLOW_XON_PASS;
    assign rx_len  = 4'(seven_bit ? 7 : 8) + {3'h0, par_en};
    // Right-align first: parity, when on, lands just above the data bits
    assign rx_al   = rx_sh_ff >> (4'h9 - rx_len);
    assign rx_word = seven_bit ? {1'b0, rx_al[6:0]} : rx_al[7:0];

    always_comb begin
        nxt_rx_st     = rx_st_ff;
        nxt_rx_cnt    = rx_cnt_ff;
        nxt_rx_bit    = rx_bit_ff;
        nxt_rx_sh     = rx_sh_ff;
        nxt_rx_data   = rx_data_ff;
        nxt_rx_valid  = 1'b0;
        nxt_rx_perr   = rx_perr_ff;
        nxt_xoff_seen = xoff_seen_ff;
        if (!rx_xon_flow)
            nxt_xoff_seen = 1'b0;
        case (rx_st_ff)
            RX_IDLE: begin
                // Half-duplex line is not received while this end drives it
                if (!rx_in_ff && !(half_duplex && tx_busy)) begin
                    nxt_rx_st  = RX_START;
                    nxt_rx_cnt = bit_div >> 1;
                end
            end
            RX_START: begin
                if (rx_cnt_ff != 16'h0000) nxt_rx_cnt = rx_cnt_ff - 16'h0001;
                else if (rx_in_ff) nxt_rx_st = RX_IDLE;
                else begin
                    nxt_rx_st  = RX_DATA;
                    nxt_rx_cnt = bit_div - 16'h0001;
                    nxt_rx_bit = 4'h0;
                    nxt_rx_sh  = 9'h000;
                end
            end
            RX_DATA: begin
                if (rx_cnt_ff != 16'h0000) nxt_rx_cnt = rx_cnt_ff - 16'h0001;
                else begin
                    nxt_rx_cnt = bit_div - 16'h0001;
                    nxt_rx_sh  = {rx_in_ff, rx_sh_ff[8:1]};
                    nxt_rx_bit = rx_bit_ff + 4'h1;
                    if (rx_bit_ff == rx_len - 4'h1) nxt_rx_st = RX_TAIL;
                end
            end
            RX_TAIL: begin
                if (rx_cnt_ff != 16'h0000) nxt_rx_cnt = rx_cnt_ff - 16'h0001;
                else begin
                    nxt_rx_st   = RX_IDLE;
                    nxt_rx_data = rx_word;
                    nxt_rx_perr = par_en && (rx_al[seven_bit ? 4'h7 : 4'h8] != (^rx_word ^ par_odd));
                    nxt_rx_valid = 1'b1;
                    if (rx_xon_flow && rx_word == CHAR_XOFF) nxt_xoff_seen = 1'b1;
                    if (rx_xon_flow && rx_word == CHAR_XON) nxt_xoff_seen = 1'b0;
                    // Plain XON/XOFF swallows the control characters
                    if (flow_control_setting_ff == FLOW_XON &&
                        (rx_word == CHAR_XON || rx_word == CHAR_XOFF)) nxt_rx_valid = 1'b0;
                end
            end
            default: nxt_rx_st = RX_IDLE;
        endcase
        if (restart) nxt_rx_st = RX_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    typedef enum logic [2:0] {
        TX_IDLE  = 3'h1,
        TX_SHIFT = 3'h2,
        TX_STOP  = 3'h4
    } slf_tx_state_type;
    slf_tx_state_type tx_st_ff, nxt_tx_st;
    logic [15:0] tx_cnt_ff, nxt_tx_cnt;
    logic [3:0]  tx_bit_ff, nxt_tx_bit;
    logic [9:0]  tx_sh_ff, nxt_tx_sh;
    logic        tx_line_ff, nxt_tx_line;
    logic        tx_paused, par_bit;
    logic [3:0]  tx_len;

    assign tx_busy  = tx_st_ff != TX_IDLE;
    assign tx_paused = (flow_control_setting_ff == FLOW_RTSCTS && cts_in_ff) ||
                       (rx_xon_flow && xoff_seen_ff);
    assign tx_ready = !tx_busy && !tx_paused && !restart;
    assign par_bit  = (seven_bit ? ^tx_data[6:0] : ^tx_data) ^ par_odd;
    assign tx_len   = 4'h1 + rx_len; // Start plus data plus parity

    always_comb begin
        nxt_tx_st   = tx_st_ff;
        nxt_tx_cnt  = tx_cnt_ff;
        nxt_tx_bit  = tx_bit_ff;
        nxt_tx_sh   = tx_sh_ff;
        nxt_tx_line = tx_line_ff;
        case (tx_st_ff)
            TX_IDLE: begin
                nxt_tx_line = 1'b1;
                if (tx_valid && tx_ready) begin
                    nxt_tx_st  = TX_SHIFT;
                    nxt_tx_cnt = bit_div - 16'h0001;
                    nxt_tx_bit = 4'h0;
                    nxt_tx_line = 1'b0;
                    nxt_tx_sh  = seven_bit ? {2'h3, par_en ? par_bit : 1'b1, tx_data[6:0]}
                                           : {1'b1, par_en ? par_bit : 1'b1, tx_data};
                end
            end
            TX_SHIFT: begin
                if (tx_cnt_ff != 16'h0000) nxt_tx_cnt = tx_cnt_ff - 16'h0001;
                else begin
                    nxt_tx_cnt = bit_div - 16'h0001;
                    nxt_tx_bit = tx_bit_ff + 4'h1;
                    if (tx_bit_ff == tx_len - 4'h1) begin
                        nxt_tx_st   = TX_STOP;
                        nxt_tx_line = 1'b1;
                        nxt_tx_bit  = 4'h0;
                    end else begin
                        nxt_tx_line = tx_sh_ff[0];
                        nxt_tx_sh   = {1'b1, tx_sh_ff[9:1]};
                    end
                end
            end
            TX_STOP: begin
                if (tx_cnt_ff != 16'h0000) nxt_tx_cnt = tx_cnt_ff - 16'h0001;
                else if (two_stop && tx_bit_ff == 4'h0) begin
                    nxt_tx_cnt = bit_div - 16'h0001;
                    nxt_tx_bit = 4'h1;
                end else nxt_tx_st = TX_IDLE;
            end
            default: nxt_tx_st = TX_IDLE;
        endcase
        if (restart) begin
            nxt_tx_st   = TX_IDLE;
            nxt_tx_line = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_st_ff     <= RX_IDLE;
            rx_cnt_ff    <= 16'h0000;
            rx_bit_ff    <= 4'h0;
            rx_sh_ff     <= 9'h000;
            rx_data_ff   <= 8'h00;
            rx_valid_ff  <= 1'b0;
            rx_perr_ff   <= 1'b0;
            xoff_seen_ff <= 1'b0;
            tx_st_ff     <= TX_IDLE;
            tx_cnt_ff    <= 16'h0000;
            tx_bit_ff    <= 4'h0;
            tx_sh_ff     <= 10'h3FF;
            tx_line_ff   <= 1'b1;
        end else begin
            rx_st_ff     <= nxt_rx_st;
            rx_cnt_ff    <= nxt_rx_cnt;
            rx_bit_ff    <= nxt_rx_bit;
            rx_sh_ff     <= nxt_rx_sh;
            rx_data_ff   <= nxt_rx_data;
            rx_valid_ff  <= nxt_rx_valid;
            rx_perr_ff   <= nxt_rx_perr;
            xoff_seen_ff <= nxt_xoff_seen;
            tx_st_ff     <= nxt_tx_st;
            tx_cnt_ff    <= nxt_tx_cnt;
            tx_bit_ff    <= nxt_tx_bit;
            tx_sh_ff     <= nxt_tx_sh;
            tx_line_ff   <= nxt_tx_line;
        end
    end

    assign rx_valid         = rx_valid_ff;
    assign rx_data          = rx_data_ff;
    assign rx_parity_err    = rx_perr_ff;
    assign serial_tx        = tx_line_ff;
    assign rts_n            = !(flow_control_setting_ff == FLOW_RTSCTS && !rx_hold);
    // Driver enable for the 2-wire bus; 4-wire keeps it on
    assign configurable_pin = (if_mode == IF_RS422) || (half_duplex && tx_busy);
endmodule : slf_serial_channel

/* File: slf_asserts.sv */
// Purpose: Port checker for the serial channel
// Assumes: One clock, async active-high reset
// Notes:   Mirrors written settings to judge mode outputs
`timescale 1ns/1ns
module slf_checker
    import slf_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       cfg_we,
    input wire logic [1:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_ready,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic       rx_parity_err,
    input wire logic       rx_hold,
    input wire logic       serial_tx,
    input wire logic       serial_rx,
    input wire logic       cts_n,
    input wire logic       rts_n,
    input wire logic       configurable_pin
);
    logic [7:0] fmt_ff, nxt_fmt, flow_ff, nxt_flow;
    always_comb begin
        nxt_fmt = (cfg_we && cfg_addr == 2'h0) ? cfg_wdata : fmt_ff;
        nxt_flow = (cfg_we && cfg_addr == 2'h1) ? cfg_wdata : flow_ff;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fmt_ff <= LINE_FMT_RST;
            flow_ff <= FLOW_RST;
        end else begin
            fmt_ff <= nxt_fmt;
            flow_ff <= nxt_flow;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_start_after_take: assert property (tx_valid && tx_ready |=> !serial_tx)
        else $error("start bit missing after take");
    a_busy_after_take: assert property (tx_valid && tx_ready |=> !tx_ready [*2])
        else $error("ready during frame");
    a_rx_one_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("receive pulse too long");
    a_rts_unused: assert property (flow_ff != FLOW_RTSCTS |-> rts_n)
        else $error("request line low outside handshake mode");
    a_rts_follows_hold: assert property (flow_ff == FLOW_RTSCTS |-> rts_n == rx_hold)
        else $error("request line does not follow hold");
    a_cts_pauses_tx: assert property ((flow_ff == FLOW_RTSCTS && cts_n) [*5] |-> !tx_ready)
        else $error("send not paused by clear-to-send");
    a_pin_four_wire: assert property (fmt_ff[1:0] == IF_RS422 |-> configurable_pin)
        else $error("driver enable low in four wire mode");
    a_pin_single_end: assert property (fmt_ff[1:0] == IF_RS232 |-> !configurable_pin)
        else $error("driver enable high in single ended mode");
    a_pin_two_wire: assert property (fmt_ff[1:0] == IF_RS485_2W && !serial_tx |-> configurable_pin)
        else $error("driver enable low while sending");
    a_fmt_readback: assert property ((cfg_we && cfg_addr == 2'h0) ##1 (cfg_addr == 2'h0)
        |-> cfg_rdata == $past(cfg_wdata)) else $error("format readback wrong");
    c_take: cover property (tx_valid && tx_ready);
    c_rx: cover property (rx_valid);
    c_two_wire: cover property (fmt_ff[1:0] == IF_RS485_2W && configurable_pin);
endmodule : slf_checker
bind slf_serial_channel slf_checker slf_checker_i (.clk(clk), .rst(rst), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_parity_err(rx_parity_err), .rx_hold(rx_hold), .serial_tx(serial_tx), .serial_rx(serial_rx),
    .cts_n(cts_n), .rts_n(rts_n), .configurable_pin(configurable_pin));

/* File: slf_far_end.sv */
// Purpose: Attached serial device model
// Assumes: Rate handed in per call; format too when receiving
// Notes:   Samples at bit middles on the falling clock edge
`timescale 1ns/1ns
module slf_far_end (
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out
);
    initial line_out = 1'b1;
    task automatic recv(input int div, input int nbits, input bit par, input int nstop,
                        output logic [7:0] data, output logic pbit, output bit ok);
        int n;
        data = 8'h00;
        pbit = 1'b0;
        n = 0;
        while (line_in !== 1'b0 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        repeat (div / 2) @(negedge clk);
        ok = (line_in === 1'b0);
        for (int i = 0; i < nbits; i++) begin
            repeat (div) @(negedge clk);
            data[i] = line_in;
        end
        if (par) begin
            repeat (div) @(negedge clk);
            pbit = line_in;
        end
        for (int i = 0; i < nstop; i++) begin
            repeat (div) @(negedge clk);
            ok &= (line_in === 1'b1);
        end
    endtask : recv
    // Always eight bits, no parity: all our traffic toward the channel uses that
    task automatic xmit(input int div, input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            line_out <= fr[i];
            repeat (div - 1) @(posedge clk);
        end
    endtask : xmit
endmodule : slf_far_end

/* File: tb.sv */
// Purpose: Self-checking bench for the serial channel
// Assumes: 10 MHz clock, far end modelled by slf_far_end
// Notes:   Fast rates keep the run short
`timescale 1ns/1ns
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin errors++; $display("[FAIL] %0t %s", $time, m); end end
module tb;
    import slf_pkg::*;
    localparam int         RATES [13] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600,
                                          115200, 230400, 460800, 921600};
    localparam logic [7:0] FMTS [7] = '{8'h4C, 8'h78, 8'h5C, 8'hCC, 8'h4D, 8'h4F, 8'hF8};
    logic       clk = 1'b0, rst = 1'b1, cfg_we = 1'b0, tx_valid = 1'b0, rx_hold = 1'b0, cts_n = 1'b0;
    logic [1:0] cfg_addr = 2'h0;
    logic [7:0] cfg_wdata = 8'h00, tx_data = 8'h00, cfg_rdata, rx_data;
    logic       tx_ready, rx_valid, rx_parity_err, serial_tx, serial_rx, rts_n, configurable_pin;
    int         errors = 0, n_checks = 0;
    logic [31:0] seed = 32'hA16180DB;
    always #50 clk = ~clk;
    slf_serial_channel slf_serial_channel_i (.clk(clk), .rst(rst), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_parity_err(rx_parity_err),
        .rx_hold(rx_hold), .serial_tx(serial_tx), .serial_rx(serial_rx), .cts_n(cts_n), .rts_n(rts_n),
        .configurable_pin(configurable_pin));
    slf_far_end slf_far_end_i (.clk(clk), .line_in(serial_tx), .line_out(serial_rx));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic int bdiv(input int idx);
        return CLK_HZ / RATES[idx];
    endfunction : bdiv
    function automatic int flen(input logic [7:0] f);
        return 1 + (f[3:2] == WL_SEVEN ? 7 : 8) + (f[5:4] != 2'h0 ? 1 : 0) + (f[7:6] == STOP_TWO ? 2 : 1);
    endfunction : flen
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        cfg_addr <= a;
        @(negedge clk);
        `CHK(cfg_rdata, e, "register readback")
    endtask : rd
    // Sends one random byte and checks it at the far end and the ready timing
    task automatic frame(input logic [7:0] f, input int idx);
        logic [7:0] d, got, em;
        logic       pb;
        bit         ok;
        int         cnt;
        d = 8'(xs());
        em = (f[3:2] == WL_SEVEN) ? {1'b0, d[6:0]} : d;
        cnt = 0;
        wr(2'h0, f);
        fork
            begin
                @(posedge clk);
                tx_valid <= 1'b1;
                tx_data <= d;
                do @(negedge clk); while (tx_ready !== 1'b1 && ++cnt < 100);
                @(posedge clk);
                tx_valid <= 1'b0;
                cnt = 0;
                do begin @(negedge clk); cnt++; end while (tx_ready !== 1'b1 && cnt < 40000);
                `CHK(cnt >= flen(f) * bdiv(idx) && cnt <= flen(f) * bdiv(idx) + 3, 1'b1, "frame length")
            end
            slf_far_end_i.recv(bdiv(idx), f[3:2] == WL_SEVEN ? 7 : 8, f[5:4] != 2'h0,
                               f[7:6] == STOP_TWO ? 2 : 1, got, pb, ok);
        join
        `CHK(got, em, "data bits")
        `CHK(ok, 1'b1, "start or stop level")
        if (f[5:4] != 2'h0) `CHK(pb, ^em ^ (f[5:4] == PAR_ODD), "parity bit")
        `CHK(configurable_pin, f[1:0] == IF_RS422, "driver enable idle")
        rd(2'h3, {6'h00, f[1:0]});
    endtask : frame
    task automatic rx_one(input int idx, input logic [7:0] b, input bit exp_v);
        bit seen;
        seen = 1'b0;
        fork
            slf_far_end_i.xmit(bdiv(idx), b);
            for (int n = 0; n < 12 * bdiv(idx); n++) begin
                @(negedge clk);
                if (rx_valid === 1'b1) begin
                    seen = 1'b1;
                    `CHK(rx_data, b, "received byte")
                    `CHK(rx_parity_err, 1'b0, "parity flag on clean byte")
                end
            end
        join
        `CHK(seen, exp_v, "receive pulse")
    endtask : rx_one
    task automatic xflow(input logic [7:0] code);
        wr(2'h1, code);
        rx_one(12, CHAR_XOFF, code == FLOW_XON_PASS);
        repeat (4) @(negedge clk);
        `CHK(tx_ready, 1'b0, "pause on stop character")
        rx_one(12, CHAR_XON, code == FLOW_XON_PASS);
        repeat (4) @(negedge clk);
        `CHK(tx_ready, 1'b1, "resume on start character")
    endtask : xflow
    task automatic end_sim;
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(2'h0, 8'h4C);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h05);
        frame(8'h4C, 5);
        wr(2'h2, 8'h0D);
        rd(2'h2, 8'h05);
        wr(2'h2, 8'h0C);
        rd(2'h2, 8'h0C);
        foreach (FMTS[i]) frame(FMTS[i], 12);
        wr(2'h2, 8'h0A);
        foreach (FMTS[i]) frame(FMTS[i], 10);
        wr(2'h0, 8'h4C);
        wr(2'h2, 8'h0C);
        repeat (3) rx_one(12, 8'(xs()), 1'b1);
        xflow(FLOW_XON_PASS);
        xflow(FLOW_XON);
        wr(2'h1, FLOW_RTSCTS);
        cts_n <= 1'b1;
        rx_hold <= 1'b1;
        repeat (5) @(negedge clk);
        `CHK(tx_ready, 1'b0, "clear-to-send pause")
        `CHK(rts_n, 1'b1, "hold raises request")
        @(posedge clk);
        cts_n <= 1'b0;
        rx_hold <= 1'b0;
        repeat (5) @(negedge clk);
        `CHK(tx_ready, 1'b1, "clear-to-send resume")
        `CHK(rts_n, 1'b0, "request low when ready")
        frame(8'h4C, 12);
        wr(2'h1, FLOW_NONE);
        cts_n <= 1'b1;
        repeat (5) @(negedge clk);
        `CHK(tx_ready, 1'b1, "no flow ignores clear-to-send")
        `CHK(rts_n, 1'b1, "no flow request high")
        end_sim;
    end
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim;
    end
endmodule : tb
